// file: verilog/txfc_tx_flow_ctrl.sv
// module: transmit flow control with packet stop, halt, interrupt toggle and loop transmit
`default_nettype none
module txfc_tx_flow_ctrl
  import txfc_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // configuration
  input  wire logic            tx_fifo_enable,
  input  wire logic            encoder_bypass,
  // host flow control pins
  input  wire logic            packet_stop_n,
  input  wire logic            interrupt_toggle_in,
  input  wire logic            loop_transmit,
  // transmit fifo read side
  input  wire logic            tx_fifo_valid,
  input  wire txfc_fifo_word_t tx_fifo_word,
  output logic                 tx_fifo_read,
  // received character stream
  input  wire logic            rx_valid,
  input  wire txfc_char_t      rx_char,
  output logic                 rx_ready,
  // encoder output, one character per clock
  output txfc_char_t           enc_char,
  output logic                 enc_from_fifo,
  // remote interrupt status
  output logic                 remote_interrupt_out
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] stop_sync_ff;
  logic [1:0] int_sync_ff;
  logic [1:0] loop_sync_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stop_sync_ff <= 2'b11;
      int_sync_ff  <= {2{RST_INT_LEVEL}};
      loop_sync_ff <= 2'b00;
    end else begin
      stop_sync_ff <= {stop_sync_ff[0], packet_stop_n};
      int_sync_ff  <= {int_sync_ff[0], interrupt_toggle_in};
      loop_sync_ff <= {loop_sync_ff[0], loop_transmit};
    end
  end

  logic stop_n;
  logic tog;
  logic loop_on;
  assign stop_n  = stop_sync_ff[1];
  assign tog     = int_sync_ff[1];
  assign loop_on = loop_sync_ff[1];

  // ----------------------------------------------------------------------
  // elasticity buffer
  // ----------------------------------------------------------------------
  logic       eb_wr_valid;
  logic       eb_wr_ready;
  logic       eb_rd_valid;
  logic       eb_rd_ready;
  txfc_char_t eb_rd_char;
  logic       rx_is_fill;

  assign rx_is_fill  = rx_char.is_cmd && (rx_char.data == CODE_FILL);
  assign eb_wr_valid = rx_valid && loop_on && !rx_is_fill;
  assign rx_ready    = rx_is_fill || !loop_on || eb_wr_ready;

  txfc_elastic_buf #(
    .DEPTH (EB_DEPTH),
    .AW    (EB_AW)
  ) u_ebuf (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (eb_wr_valid),
    .wr_char  (rx_char),
    .wr_ready (eb_wr_ready),
    .rd_valid (eb_rd_valid),
    .rd_char  (eb_rd_char),
    .rd_ready (eb_rd_ready)
  );

  // ----------------------------------------------------------------------
  // remote interrupt status from received codes
  // ----------------------------------------------------------------------
  logic rem_int_ff;
  logic nxt_rem_int;

  always_comb begin
    nxt_rem_int = rem_int_ff;
    if (rx_valid && rx_char.is_cmd && rx_char.data == CODE_INT_RISE) begin
      nxt_rem_int = 1'b1;
    end else if (rx_valid && rx_char.is_cmd && rx_char.data == CODE_INT_FALL) begin
      nxt_rem_int = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rem_int_ff <= RST_REM_INT;
    end else begin
      rem_int_ff <= nxt_rem_int;
    end
  end

  assign remote_interrupt_out = rem_int_ff;

  // ----------------------------------------------------------------------
  // transmit controller
  // ----------------------------------------------------------------------
  txfc_state_t state_ff;
  txfc_state_t nxt_state;
  logic        tog_prev_ff;
  logic        nxt_tog_prev;
  logic        int_pend_ff;
  logic        nxt_int_pend;
  logic        int_lvl_ff;
  logic        nxt_int_lvl;
  txfc_char_t  out_ff;
  txfc_char_t  nxt_out;
  logic        from_fifo_ff;
  logic        nxt_from_fifo;
  logic        halt_now;
  logic        soc_seen;

  always_comb begin
    nxt_state     = state_ff;
    nxt_tog_prev  = tog_prev_ff;
    nxt_int_pend  = int_pend_ff;
    nxt_int_lvl   = int_lvl_ff;
    nxt_out       = '{is_cmd: 1'b1, data: CODE_FILL};
    nxt_from_fifo = 1'b0;
    tx_fifo_read  = 1'b0;
    eb_rd_ready   = 1'b0;
    // halt on halt_bit (word bit 8) low unless encoder bypassed; stop acts as halt when bypassed
    halt_now = encoder_bypass ? !stop_n
                              : (tx_fifo_valid && !tx_fifo_word.halt_bit);
    soc_seen = tx_fifo_valid && tx_fifo_word.cell_start && !encoder_bypass;
    if (tx_fifo_enable) begin
      if (tog != tog_prev_ff) begin
        nxt_tog_prev = tog;
        nxt_int_pend = 1'b1;
        nxt_int_lvl  = tog;
      end
      if (int_pend_ff) begin
        // interrupt code takes one slot, data resumes next character
        nxt_out.data = int_lvl_ff ? CODE_INT_RISE : CODE_INT_FALL;
        nxt_int_pend = (tog != tog_prev_ff);
      end else if (loop_on) begin
        if (eb_rd_valid) begin
          eb_rd_ready = 1'b1;
          nxt_out     = eb_rd_char;
        end
      end else if (!halt_now && tx_fifo_valid) begin
        unique case (state_ff)
          TXFC_RUN, TXFC_CELL: begin
            if (soc_seen && !stop_n) begin
              nxt_state = TXFC_HOLD;
            end else begin
              tx_fifo_read  = 1'b1;
              nxt_from_fifo = 1'b1;
              nxt_out       = '{is_cmd: 1'b0, data: tx_fifo_word.data};
              nxt_state     = soc_seen ? TXFC_CELL : state_ff;
            end
          end
          TXFC_HOLD: begin
            if (stop_n) begin
              tx_fifo_read  = 1'b1;
              nxt_from_fifo = 1'b1;
              nxt_out       = '{is_cmd: 1'b0, data: tx_fifo_word.data};
              nxt_state     = TXFC_CELL;
            end
          end
        endcase
      end
    end else begin
      nxt_tog_prev = tog;
      nxt_state    = TXFC_RUN;
      if (tx_fifo_valid) begin
        tx_fifo_read  = 1'b1;
        nxt_from_fifo = 1'b1;
        nxt_out       = '{is_cmd: 1'b0, data: tx_fifo_word.data};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff     <= TXFC_RUN;
      tog_prev_ff  <= RST_INT_LEVEL;
      int_pend_ff  <= 1'b0;
      int_lvl_ff   <= RST_INT_LEVEL;
      out_ff       <= '{is_cmd: 1'b1, data: CODE_FILL};
      from_fifo_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      tog_prev_ff  <= nxt_tog_prev;
      int_pend_ff  <= nxt_int_pend;
      int_lvl_ff   <= nxt_int_lvl;
      out_ff       <= nxt_out;
      from_fifo_ff <= nxt_from_fifo;
    end
  end

  assign enc_char      = out_ff;
  assign enc_from_fifo = from_fifo_ff;

endmodule : txfc_tx_flow_ctrl
`default_nettype wire

// file: pkg/txfc_pkg.sv
// package: constants and carrier types for the transmit flow-control block
`default_nettype none
package txfc_pkg;

  // ----------------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------------
  localparam int CHAR_W       = 8;
  localparam int EB_DEPTH     = 8;
  localparam int EB_AW        = 3;
  localparam int SYNC_STAGES  = 2;

  // ----------------------------------------------------------------------
  // special character codes (low byte of the command code space)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_FILL      = 8'h0_5;
  localparam logic [7:0] CODE_INT_RISE  = 8'h0_0;
  localparam logic [7:0] CODE_INT_FALL  = 8'h0_3;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic RST_INT_LEVEL = 1'b0;
  localparam logic RST_REM_INT   = 1'b0;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              cell_start;
    logic              halt_bit;
    logic [CHAR_W-1:0] data;
  } txfc_fifo_word_t;

  typedef struct packed {
    logic              is_cmd;
    logic [CHAR_W-1:0] data;
  } txfc_char_t;

  typedef enum logic [1:0] {
    TXFC_RUN  = 2'b00,
    TXFC_CELL = 2'b01,
    TXFC_HOLD = 2'b11
  } txfc_state_t;

endpackage : txfc_pkg
`default_nettype wire

// file: verilog/txfc_elastic_buf.sv
// module: eight-character elasticity buffer between receive and transmit paths
`default_nettype none
module txfc_elastic_buf
  import txfc_pkg::*;
#(
  parameter int DEPTH = EB_DEPTH,
  parameter int AW    = EB_AW
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // write side
  input  wire logic       wr_valid,
  input  wire txfc_char_t wr_char,
  output logic            wr_ready,
  // read side
  output logic            rd_valid,
  output txfc_char_t      rd_char,
  input  wire logic       rd_ready
);

  // ----------------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------------
  txfc_char_t     mem_ff [DEPTH];
  logic [AW:0]    wp_ff;
  logic [AW:0]    rp_ff;
  logic [AW:0]    nxt_wp;
  logic [AW:0]    nxt_rp;
  logic           do_wr;
  logic           do_rd;

  localparam logic [AW:0] PTR_INC = {{AW{1'b0}}, 1'b1};

  always_comb begin
    rd_valid = (wp_ff != rp_ff);
    wr_ready = (wp_ff[AW-1:0] != rp_ff[AW-1:0]) || (wp_ff[AW] == rp_ff[AW]);
    rd_char  = mem_ff[rp_ff[AW-1:0]];
    do_wr    = wr_valid && wr_ready;
    do_rd    = rd_valid && rd_ready;
    nxt_wp   = do_wr ? wp_ff + PTR_INC : wp_ff;
    nxt_rp   = do_rd ? rp_ff + PTR_INC : rp_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
    if (do_wr) begin
      mem_ff[wp_ff[AW-1:0]] <= wr_char;
    end
  end

endmodule : txfc_elastic_buf
`default_nettype wire

// file: verification/txfc_flow_sva.sv
// checker: port checks for the transmit flow-control block
`default_nettype none
module txfc_flow_sva
  import txfc_pkg::*;
(
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            rst,
  // control pins
  input wire logic            tx_fifo_enable,
  input wire logic            encoder_bypass,
  input wire logic            packet_stop_n,
  input wire logic            interrupt_toggle_in,
  input wire logic            loop_transmit,
  // fifo and streams
  input wire logic            tx_fifo_valid,
  input wire txfc_fifo_word_t tx_fifo_word,
  input wire logic            tx_fifo_read,
  input wire logic            rx_valid,
  input wire txfc_char_t      rx_char,
  input wire logic            rx_ready,
  input wire txfc_char_t      enc_char,
  input wire logic            enc_from_fifo,
  input wire logic            remote_interrupt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_echo: assert property (tx_fifo_read |=> enc_from_fifo && !enc_char.is_cmd
    && enc_char.data == $past(tx_fifo_word.data)) else $error("read word not sent");
  a_src_read: assert property (enc_from_fifo |-> $past(tx_fifo_read))
    else $error("fifo flag without read");
  a_halt_block: assert property (tx_fifo_enable && !encoder_bypass && tx_fifo_valid
    && !tx_fifo_word.halt_bit |-> !tx_fifo_read) else $error("read past halt");
  a_stop_hold: assert property ((!packet_stop_n)[*3] ##0 (tx_fifo_enable && tx_fifo_valid
    && (encoder_bypass || tx_fifo_word.cell_start)) |-> !tx_fifo_read) else $error("stop ignored");
  a_rint_set: assert property (rx_valid && rx_char.is_cmd && rx_char.data == CODE_INT_RISE
    |=> remote_interrupt_out) else $error("remote int not set");
  a_rint_clr: assert property (rx_valid && rx_char.is_cmd && rx_char.data == CODE_INT_FALL
    |=> !remote_interrupt_out) else $error("remote int not cleared");
  a_rx_ready: assert property ((!loop_transmit)[*3] |-> rx_ready)
    else $error("rx refused outside loop");
  a_int_rise: assert property ($rose(interrupt_toggle_in) && tx_fifo_enable |-> ##[1:6]
    (enc_char.is_cmd && enc_char.data == CODE_INT_RISE)) else $error("no rise code");
endmodule : txfc_flow_sva

bind txfc_tx_flow_ctrl txfc_flow_sva u_sva (.sys_clk, .rst, .tx_fifo_enable, .encoder_bypass,
  .packet_stop_n, .interrupt_toggle_in, .loop_transmit, .tx_fifo_valid, .tx_fifo_word,
  .tx_fifo_read, .rx_valid, .rx_char, .rx_ready, .enc_char, .enc_from_fifo, .remote_interrupt_out);
`default_nettype wire

// file: verification/txfc_host_model.sv
// host model: transmit fifo read side feeding the block
`default_nettype none
module txfc_host_model
  import txfc_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // bench side
  input wire logic             push_valid,
  input wire txfc_fifo_word_t  push_word,
  input wire logic             clr_halt,
  // block side
  input wire logic             tx_fifo_read,
  output logic                 tx_fifo_valid,
  output txfc_fifo_word_t      tx_fifo_word
);
  timeunit 1ns;
  timeprecision 1ps;
  txfc_fifo_word_t mem_ff [64];
  logic [5:0]      wr_ff, rd_ff, tick_ff;
  assign tx_fifo_valid = (wr_ff != rd_ff);
  // empty head shows a moving pattern, not a stale word
  assign tx_fifo_word = tx_fifo_valid ? mem_ff[rd_ff] : txfc_fifo_word_t'({4'h0, tick_ff});
  always_ff @(posedge sys_clk) begin
    tick_ff <= rst ? 6'h00 : tick_ff + 6'h01;
    if (rst) begin
      wr_ff <= 6'h00;
      rd_ff <= 6'h00;
    end else begin
      if (push_valid) begin
        mem_ff[wr_ff] <= push_word;
        wr_ff         <= wr_ff + 6'h01;
      end
      if (tx_fifo_read) rd_ff <= rd_ff + 6'h01;
      if (clr_halt) mem_ff[rd_ff].halt_bit <= 1'b1;
    end
  end
endmodule : txfc_host_model
`default_nettype wire

// file: verification/testbench.sv
// testbench: scenario tasks for the transmit flow-control block
`default_nettype none
module testbench
  import txfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            sys_clk, rst, en, byp, stop_n, tgl, loop, pv, clr;
  logic            rv, vld, rd, rdy, efrom, rint;
  txfc_fifo_word_t pw, word;
  txfc_char_t      rc, enc;
  int              errors, num_checks;
  logic [7:0]      got[$], lp[$];
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  txfc_tx_flow_ctrl dut (.sys_clk(sys_clk), .rst(rst), .tx_fifo_enable(en), .encoder_bypass(byp),
    .packet_stop_n(stop_n), .interrupt_toggle_in(tgl), .loop_transmit(loop), .tx_fifo_valid(vld),
    .tx_fifo_word(word), .tx_fifo_read(rd), .rx_valid(rv), .rx_char(rc), .rx_ready(rdy),
    .enc_char(enc), .enc_from_fifo(efrom), .remote_interrupt_out(rint));
  txfc_host_model host (.sys_clk(sys_clk), .rst(rst), .push_valid(pv), .push_word(pw),
    .clr_halt(clr), .tx_fifo_read(rd), .tx_fifo_valid(vld), .tx_fifo_word(word));
  always @(posedge sys_clk) begin
    if (efrom === 1'b1) got.push_back(enc.data);
    if (efrom === 1'b0 && enc.is_cmd === 1'b0) lp.push_back(enc.data);
  end
  task close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task push(input logic [9:0] w);
    pv <= 1'b1;
    pw <= w;
    wt(1);
    pv <= 1'b0;
    wt(1);
  endtask : push
  task wait_got(input int n);
    for (int i = 0; i < 60 && got.size() < n; i++) wt(1);
    chk(got.size() >= n, "read timeout");
    if (got.size() < n) close_out();
  endtask : wait_got
  task cmp(input int n, input logic [7:0] e0, input logic [7:0] e1);
    chk(got.size() == n, "read count");
    if (got.size() > 0) chk(got[0] === e0, "read data");
    if (n > 1 && got.size() > 1) chk(got[1] === e1, "read data");
    got.delete();
  endtask : cmp
  task rx_send(input logic [8:0] c);
    rv <= 1'b1;
    rc <= c;
    for (int i = 0; i < 20; i++) begin
      wt(1);
      if (rdy === 1'b1) break;
    end
    chk(rdy === 1'b1, "rx timeout");
    if (rdy !== 1'b1) close_out();
    rv <= 1'b0;
    rc <= ~c;
    wt(1);
  endtask : rx_send
  task wait_code(input logic [7:0] c);
    for (int i = 0; i < 20 && !(enc.is_cmd === 1'b1 && enc.data === c); i++) wt(1);
    chk(enc.is_cmd === 1'b1 && enc.data === c, "code timeout");
    if (!(enc.is_cmd === 1'b1 && enc.data === c)) close_out();
  endtask : wait_code
  task t_stop();
    stop_n <= 1'b0;
    wt(4);
    push({1'b0, 1'b1, 8'ha1});
    push({1'b1, 1'b1, 8'hb2});
    push({1'b0, 1'b1, 8'hc3});
    push({1'b1, 1'b1, 8'hd4});
    wt(8);
    cmp(1, 8'ha1, 8'h00);
    stop_n <= 1'b1;
    wt(1);
    stop_n <= 1'b0;
    wt(12);
    cmp(2, 8'hb2, 8'hc3);
    stop_n <= 1'b1;
    wait_got(1);
    cmp(1, 8'hd4, 8'h00);
  endtask : t_stop
  task t_halt();
    push({1'b0, 1'b0, 8'h55});
    wt(8);
    chk(got.size() == 0, "read past halt");
    chk(enc === {1'b1, CODE_FILL}, "no fill while halted");
    clr <= 1'b1;
    wt(1);
    clr <= 1'b0;
    wait_got(1);
    cmp(1, 8'h55, 8'h00);
  endtask : t_halt
  task t_byp();
    byp <= 1'b1;
    push({1'b0, 1'b0, 8'h66});
    wait_got(1);
    cmp(1, 8'h66, 8'h00);
    stop_n <= 1'b0;
    wt(4);
    push({1'b0, 1'b1, 8'h77});
    wt(8);
    chk(got.size() == 0, "stop ignored in bypass");
    stop_n <= 1'b1;
    wait_got(1);
    cmp(1, 8'h77, 8'h00);
    byp <= 1'b0;
  endtask : t_byp
  task t_loop();
    loop <= 1'b1;
    wt(4);
    lp.delete();
    push({1'b0, 1'b1, 8'h88});
    rx_send({1'b0, 8'h11});
    rx_send({1'b1, CODE_FILL});
    rx_send({1'b0, 8'h22});
    wt(10);
    chk(got.size() == 0, "tx fifo read in loop");
    chk(lp.size() == 2 && lp[0] === 8'h11 && lp[1] === 8'h22, "loop data");
    loop <= 1'b0;
    wait_got(1);
    cmp(1, 8'h88, 8'h00);
  endtask : t_loop
  task t_int();
    tgl <= 1'b1;
    wait_code(CODE_INT_RISE);
    tgl <= 1'b0;
    wait_code(CODE_INT_FALL);
    rx_send({1'b1, CODE_INT_RISE});
    chk(rint === 1'b1, "remote int not set");
    rx_send({1'b1, CODE_INT_FALL});
    chk(rint === 1'b0, "remote int not cleared");
  endtask : t_int
  task t_rst();
    rx_send({1'b1, CODE_INT_RISE});
    chk(rint === 1'b1, "remote int not set before reset");
    rst <= 1'b1;
    wt(3);
    chk(rint === RST_REM_INT && efrom === 1'b0, "reset state");
    chk(enc === {1'b1, CODE_FILL}, "no fill in reset");
    rst <= 1'b0;
    wt(2);
    push({1'b0, 1'b1, 8'h3c});
    wait_got(1);
    cmp(1, 8'h3c, 8'h00);
  endtask : t_rst
  task t_off();
    en <= 1'b0;
    stop_n <= 1'b0;
    wt(4);
    push({1'b1, 1'b0, 8'h99});
    wait_got(1);
    cmp(1, 8'h99, 8'h00);
  endtask : t_off
  initial begin
    {rst, en, stop_n} = 3'b111;
    {byp, tgl, loop, pv, clr, rv} = 6'h00;
    pw = '0;
    rc = '0;
    errors = 0;
    num_checks = 0;
    wt(16);
    rst <= 1'b0;
    wt(2);
    t_stop();
    $display("test stop done");
    t_halt();
    $display("test halt done");
    t_byp();
    $display("test bypass done");
    t_loop();
    $display("test loop done");
    t_int();
    $display("test interrupt done");
    t_rst();
    $display("test reset done");
    t_off();
    $display("test fifo off done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
